// file: verilog/pmv_pkg.sv
// Package for the program memory and vector map block.
// Assumes a single core clock; shared by the fetch sequencer and the store.
package pmv_pkg;
  localparam int          PC_WIDTH     = 16;
  localparam int          DATA_WIDTH   = 8;
  localparam int          ROM_BYTES    = 32768;
  localparam int          ROM_AW       = 15;
  localparam int          NUM_SOURCES  = 8;
  localparam int          SRC_WIDTH    = 3;
  localparam logic [15:0] RESET_PC     = 16'h0000;
  localparam logic [15:0] VEC_BASE     = 16'h0003;
  localparam logic [15:0] VEC_STRIDE   = 16'h0008;
  localparam logic [15:0] VEC_EXT0     = 16'h0003;
  localparam logic [15:0] VEC_TMR0     = 16'h000b;
  localparam logic [15:0] VEC_EXT1     = 16'h0013;
  localparam logic [15:0] VEC_TMR1     = 16'h001b;
  localparam logic [15:0] PC_STEP      = 16'h0001;
  localparam logic [7:0]  ROM_FILL     = 8'hff;
  localparam logic [7:0]  DMEM_RESET   = 8'h00;
endpackage

// file: verilog/pmv_rom.sv
// Read-only on-chip program store, one byte per fetch.
// Assumes the address is already a full sixteen-bit fetch address.
`timescale 1ns/100ps
`default_nettype none
module pmv_rom (
  input  wire logic                             clk,
  input  wire logic [pmv_pkg::PC_WIDTH-1:0]     addr,
  input  wire logic [pmv_pkg::DATA_WIDTH-1:0]   loadData,
  input  wire logic                             loadEn,
  output logic      [pmv_pkg::DATA_WIDTH-1:0]   rdata
);
  // Contents come only from the programming path, never from the core.
  logic [pmv_pkg::DATA_WIDTH-1:0] mem [pmv_pkg::ROM_BYTES];
  logic [pmv_pkg::ROM_AW-1:0]     idx;

  // Addresses above the populated range alias down into the store.
  assign idx = addr[pmv_pkg::ROM_AW-1:0];

  always_ff @(posedge clk) begin
    if (loadEn) begin
      mem[idx] <= loadData;
    end
    rdata <= mem[idx];
  end
endmodule
`default_nettype wire

// file: verilog/pmv_fetch.sv
// Program fetch sequencer with fixed interrupt vectors and data port split.
// Assumes the interrupt controller presents an accepted source with a pulse.
// Core writes to the program store arrive on a port of their own and are dropped.
// The store and the data array have no reset; pc, instr, instrValid, dataRd and readPending do.
`timescale 1ns/100ps
`default_nettype none
module pmv_fetch (
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  input  wire logic                             fetchEn,
  input  wire logic                             jumpEn,
  input  wire logic [pmv_pkg::PC_WIDTH-1:0]     jumpAddr,
  input  wire logic                             intAccept,
  input  wire logic [pmv_pkg::SRC_WIDTH-1:0]    intSource,
  input  wire logic                             progWrEn,
  input  wire logic [pmv_pkg::DATA_WIDTH-1:0]   progWrData,
  input  wire logic                             romLoadEn,
  input  wire logic [pmv_pkg::DATA_WIDTH-1:0]   romLoadData,
  input  wire logic [pmv_pkg::DATA_WIDTH-1:0]   dataAddr,
  input  wire logic                             dataWrEn,
  input  wire logic [pmv_pkg::DATA_WIDTH-1:0]   dataWrData,
  output logic      [pmv_pkg::PC_WIDTH-1:0]     pc,
  output logic      [pmv_pkg::DATA_WIDTH-1:0]   instr,
  output logic                                  instrValid,
  output logic      [pmv_pkg::DATA_WIDTH-1:0]   dataRd,
  output logic                                  extBusReq
);

  typedef enum logic [1:0] {PMV_IDLE, PMV_VECTOR, PMV_JUMP, PMV_STEP} pmv_req_e;
  typedef logic [pmv_pkg::PC_WIDTH-1:0] pmv_addr_t;

  // These carry the request decode and the program counter.
  pmv_req_e                       request;
  logic [pmv_pkg::PC_WIDTH-1:0]   vecTable [pmv_pkg::NUM_SOURCES];
  logic [pmv_pkg::PC_WIDTH-1:0]   vecAddr;
  logic [pmv_pkg::PC_WIDTH-1:0]   seqAddr;
  logic [pmv_pkg::PC_WIDTH-1:0]   fetchAddr;
  logic [pmv_pkg::PC_WIDTH-1:0]   next_pc;

  // These connect the program store.
  logic                           storeWrEn;
  logic [pmv_pkg::DATA_WIDTH-1:0] storeWrData;
  logic [pmv_pkg::DATA_WIDTH-1:0] romData;

  // These stage the fetch flag and the fetched byte.
  logic                           readPending;
  logic                           next_readPending;
  logic                           next_instrValid;
  logic [pmv_pkg::DATA_WIDTH-1:0] next_instr;

  // This holds the next external bus request.
  logic                           next_extBusReq;

  // These hold the data space and its port.
  logic [pmv_pkg::DATA_WIDTH-1:0] dmem [2**pmv_pkg::DATA_WIDTH];
  logic [pmv_pkg::DATA_WIDTH-1:0] dataIdx;
  logic                           dataWrite;
  logic [pmv_pkg::DATA_WIDTH-1:0] next_dataRd;

  // An interrupt outranks a jump, and a jump outranks a sequential fetch.
  always_comb begin
    request = PMV_IDLE;
    if (intAccept) begin
      request = PMV_VECTOR;
    end else if (jumpEn) begin
      request = PMV_JUMP;
    end else if (fetchEn) begin
      request = PMV_STEP;
    end
  end

  // Every slot follows the stride, so sources past the named four need no table.
  for (genvar k = 0; k < pmv_pkg::NUM_SOURCES; k++) begin : g_vec
    assign vecTable[k] = pmv_pkg::VEC_BASE + pmv_pkg::VEC_STRIDE * pmv_addr_t'(k);
  end

  // The named four stay explicit so that a change of stride cannot move them.
  always_comb begin
    case (intSource)
      3'h0: begin
        vecAddr = pmv_pkg::VEC_EXT0;
      end
      3'h1: begin
        vecAddr = pmv_pkg::VEC_TMR0;
      end
      3'h2: begin
        vecAddr = pmv_pkg::VEC_EXT1;
      end
      3'h3: begin
        vecAddr = pmv_pkg::VEC_TMR1;
      end
      default: begin
        vecAddr = vecTable[intSource];
      end
    endcase
  end

  // Vector slots are fetched like any other byte, so the step never skips them.
  always_comb begin
    seqAddr = pc + pmv_pkg::PC_STEP;
  end

  // The fetch address is the whole counter; only the store folds the top bit.
  assign fetchAddr = pc;

  // Only the programming path reaches the store; core writes stop at the port.
  always_comb begin
    storeWrEn   = romLoadEn;
    storeWrData = romLoadData;
  end

  pmv_rom u_rom (
    .clk      (clk),
    .addr     (fetchAddr),
    .loadData (storeWrData),
    .loadEn   (storeWrEn),
    .rdata    (romData)
  );

  // A vector or a jump replaces the counter; a fetch steps it.
  always_comb begin
    case (request)
      PMV_VECTOR: begin
        next_pc = vecAddr;
      end
      PMV_JUMP: begin
        next_pc = jumpAddr;
      end
      PMV_STEP: begin
        next_pc = seqAddr;
      end
      default: begin
        next_pc = pc;
      end
    endcase
    if (!rst_n) begin
      next_pc = pmv_pkg::RESET_PC;
    end
  end

  // Reset enters through next_pc, so the register itself stays a plain flop.
  always_ff @(posedge clk) begin
    pc <= next_pc;
  end

  // Only a sequential fetch sets readPending; a redirect raises no flag.
  always_comb begin
    next_readPending = (request == PMV_STEP);
    next_instrValid  = readPending;
    if (!rst_n) begin
      next_readPending = 1'b0;
      next_instrValid  = 1'b0;
    end
  end

  // The flag is a single-cycle pulse for each fetched byte.
  always_ff @(posedge clk) begin
    readPending <= next_readPending;
    instrValid  <= next_instrValid;
  end

  // The byte register follows the store every cycle; the flag says when it counts.
  always_comb begin
    next_instr = romData;
    if (!rst_n) begin
      next_instr = pmv_pkg::ROM_FILL;
    end
  end

  // Reset parks the byte register at the value of an unprogrammed byte.
  always_ff @(posedge clk) begin
    instr <= next_instr;
  end

  // All fetches are served on chip, so the external request never rises.
  always_comb begin
    next_extBusReq = 1'b0;
  end

  always_ff @(posedge clk) begin
    extBusReq <= next_extBusReq;
  end

  // Data space is a separate byte-addressed array, never the program store.
  always_comb begin
    dataIdx   = dataAddr;
    dataWrite = dataWrEn;
  end

  // Reads take the address as it stands; the byte appears after the next edge.
  always_comb begin
    next_dataRd = dmem[dataIdx];
    if (!rst_n) begin
      next_dataRd = pmv_pkg::DMEM_RESET;
    end
  end

  // A read of the byte being written returns the old value for one cycle.
  always_ff @(posedge clk) begin
    if (dataWrite) begin
      dmem[dataIdx] <= dataWrData;
    end
  end

  // The read port is registered so the output comes straight from a flop.
  always_ff @(posedge clk) begin
    dataRd <= next_dataRd;
  end
endmodule
`default_nettype wire

// file: test/pmv_fetch_asserts.sv
// Checker on the fetch sequencer ports.
// Assumes it is bound to pmv_fetch.
`timescale 1ns/100ps
`default_nettype none
module pmv_fetch_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        jumpEn,
  input wire logic [15:0] jumpAddr,
  input wire logic        intAccept,
  input wire logic [2:0]  intSource,
  input wire logic [15:0] pc,
  input wire logic        extBusReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rst; disable iff (1'h0) !rst_n |=> pc == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("pc not cleared");
  property p_ext0; intAccept && intSource == 3'h0 |=> pc == 16'h0003; endproperty
  a_ext0: assert property (p_ext0) else $error("vector 0 wrong");
  property p_tmr0; intAccept && intSource == 3'h1 |=> pc == 16'h000b; endproperty
  a_tmr0: assert property (p_tmr0) else $error("vector 1 wrong");
  property p_ext1; intAccept && intSource == 3'h2 |=> pc == 16'h0013; endproperty
  a_ext1: assert property (p_ext1) else $error("vector 2 wrong");
  property p_tmr1; intAccept && intSource == 3'h3 |=> pc == 16'h001b; endproperty
  a_tmr1: assert property (p_tmr1) else $error("vector 3 wrong");
  property p_vec; intAccept |=> pc == 16'h0003 + {10'h000, $past(intSource), 3'h0}; endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  property p_jmp; jumpEn && !intAccept |=> pc == $past(jumpAddr); endproperty
  a_jmp: assert property (p_jmp) else $error("jump wrong");
  property p_bus; extBusReq == 1'h0; endproperty
  a_bus: assert property (p_bus) else $error("external cycle");
  c_int: cover property (intAccept ##1 pc[2:0] == 3'h3);
  c_jmp: cover property (jumpEn ##1 pc[15]);
  c_rst: cover property ($rose(rst_n));
endmodule
bind pmv_fetch pmv_fetch_asserts pmv_fetch_asserts_i (.clk(clk), .rst_n(rst_n), .jumpEn(jumpEn),
  .jumpAddr(jumpAddr), .intAccept(intAccept), .intSource(intSource), .pc(pc),
  .extBusReq(extBusReq));
`default_nettype wire

// file: test/pmv_int_seq.sv
// Interrupt sequencer model: one request cycle gives one accept pulse.
// Assumes requests are held for a single cycle.
`timescale 1ns/100ps
`default_nettype none
module pmv_int_seq (
  input  wire logic       clk,
  input  wire logic       req,
  input  wire logic [2:0] reqSrc,
  output logic            intAccept,
  output logic [2:0]      intSource
);
  // The source is inverted while idle so a stale value is never trusted.
  always_ff @(posedge clk) begin
    intAccept <= req;
    intSource <= req ? reqSrc : ~reqSrc;
  end
endmodule
`default_nettype wire

// file: test/tb_pmv_fetch.sv
// Bench: vectors, store and data space of the fetch sequencer.
// Assumes the package, design and interrupt model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_pmv_fetch;
  logic clk = '0, rst_n = '0, fetchEn = '0, jumpEn = '0, req = '0, progWrEn = '0;
  logic romLoadEn = '0, dataWrEn = '0, intAccept, instrValid, extBusReq;
  logic [15:0] jumpAddr = '0, pc;
  logic [7:0] romLoadData = '0, progWrData = '0, dataAddr = '0, dataWrData = '0, instr, dataRd;
  logic [2:0] reqSrc = '0, intSource;
  int n_mismatch = 0, checks = 0, v, rom[$], dmem[$];
  always #12.5 clk = ~clk;
  pmv_int_seq pmv_int_seq_i (.clk(clk), .req(req), .reqSrc(reqSrc), .intAccept(intAccept),
    .intSource(intSource));
  pmv_fetch pmv_fetch_i (.clk(clk), .rst_n(rst_n), .fetchEn(fetchEn), .jumpEn(jumpEn),
    .jumpAddr(jumpAddr), .intAccept(intAccept), .intSource(intSource), .progWrEn(progWrEn),
    .progWrData(progWrData), .romLoadEn(romLoadEn), .romLoadData(romLoadData),
    .dataAddr(dataAddr), .dataWrEn(dataWrEn), .dataWrData(dataWrData), .pc(pc),
    .instr(instr), .instrValid(instrValid), .dataRd(dataRd), .extBusReq(extBusReq));
  task automatic chk(input logic [15:0] seen, exp, input string nm);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic jmp(input logic [15:0] a);
    jumpAddr = a; jumpEn = 1'h1; cyc(1); jumpEn = 1'h0;
    chk(pc, a, "pc");
  endtask
  // A write attempt rides on every fetch; the store must ignore it.
  task automatic fch(input int i);
    fetchEn = 1'h1; progWrEn = 1'h1; progWrData = ~romLoadData; cyc(1);
    fetchEn = 1'h0; progWrEn = 1'h0; cyc(1);
    chk(16'(instrValid), 16'h0001, "valid");
    chk(16'(extBusReq), 16'h0000, "bus");
    chk(16'(instr), 16'(rom[i]), "instr");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(62774));
    cyc(16);
    rst_n = 1'h1;
    chk(pc, 16'h0000, "pc");
    for (int i = 0; i < 8; i++) begin
      v = 3 + 8 * i; rom.push_back($urandom % 256); dmem.push_back($urandom % 256);
      jmp(16'(v));
      romLoadEn = 1'h1; romLoadData = 8'(rom[i]); dataWrEn = 1'h1;
      dataAddr = 8'(i * 37); dataWrData = 8'(dmem[i]); cyc(1);
      romLoadEn = 1'h0; dataWrEn = 1'h0; req = 1'h1; reqSrc = 3'(i); cyc(1);
      req = 1'h0; cyc(1);
      chk(pc, 16'(v), "vector");
      chk(16'(dataRd), 16'(dmem[i]), "data");
      fch(i);
      jmp(16'(v) | 16'h8000);
      fch(i);
      $display("test %0d done", i);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
